// File: dma8_controller.v
// Purpose: Eight-channel transfer controller with APB register slave
// Assumes: Single clock; ram and peripheral reads return data one cycle after the read strobe
// Notes:   One transfer in flight at a time on its own transaction bus
//
// Notes on behaviour
// [RL1] Eight identical channels, each with own registers
// [RL2] Channel moves RAM to peripheral or back
// [RL3] Own transaction bus, never stalls the processor
// [RL4] Post-increment, no-increment, or peripheral indirect addressing
// [RL5] Interrupt at block end, or at half
// [RL6] Byte or word per transfer
// [RL7] Simultaneous requests granted by fixed priority
// [RL8] Start by software force or peripheral request
// [RL9] One-shot stops, auto-repeat restarts the block
// [RL10] Ping-pong swaps start addresses after each block
// [RL11] Trigger chosen by seven-bit source code
// [RL12] Serial receiver: code 0001011, address 0x0226
// [RL13] Compare one: code 0000010, 0x0182 and 0x0180
// [RL14] Converter done: code 0001101, result at 0x0300
// [RL15] Start-address read returns current pointer
// [RL16] Per-channel register set with ten-bit count
// [RL17] Shared collision and activity/ping-pong status registers
// [RL18] Interrupt controller holds flags; one request per channel
// [RL19] Transfers per block equal count plus one
// [RL20] Address mode 11 acts as peripheral indirect
// [RL21] Force cleared by hardware only, after transfer
// [RL22] Direction bit selects source bus
// [RL23] Lower-numbered channel wins a tie
// [RL24] Writes while enabled give no guarantee
`timescale 1ns/1ps
`include "dma8_consts.vh"

module dma8_controller #(
  parameter NCH  = 8,
  parameter NSRC = 128
) (
  input  wire            pclk,
  input  wire            presetn,
  input  wire            ce,
  input  wire            psel,
  input  wire            penable,
  input  wire            pwrite,
  input  wire [11:0]     paddr,
  input  wire [31:0]     pwdata,
  output reg  [31:0]     prdata,
  output reg             pready,
  output reg             pslverr,
  input  wire [NSRC-1:0] irq_src,
  input  wire [15:0]     periph_ind_addr,
  output reg  [15:0]     ram_addr,
  output reg  [15:0]     ram_wdata,
  input  wire [15:0]     ram_rdata,
  output reg             ram_re,
  output reg             ram_we,
  output reg             xfer_byte,
  output reg  [15:0]     per_addr,
  output reg  [15:0]     per_wdata,
  input  wire [15:0]     per_rdata,
  output reg             per_re,
  output reg             per_we,
  input  wire            cpu_ram_we,
  input  wire [15:0]     cpu_ram_addr,
  input  wire            cpu_per_we,
  input  wire [15:0]     cpu_per_addr,
  output reg  [NCH-1:0]  chan_irq
);

  localparam S_IDLE = 2'h0;
  localparam S_RD   = 2'h1;
  localparam S_WAIT = 2'h2;
  localparam S_WR   = 2'h3;

  // ****************************************************************
  // Channel state
  // ****************************************************************
  reg  [15:0]    ctl_r   [0:NCH-1];
  reg  [6:0]     sel_r   [0:NCH-1];
  reg  [15:0]    sta_r   [0:NCH-1];
  reg  [15:0]    stb_r   [0:NCH-1];
  reg  [15:0]    pad_r   [0:NCH-1];
  reg  [9:0]     cnt_r   [0:NCH-1];
  reg  [15:0]    ptr_r   [0:NCH-1];
  reg  [9:0]     idx_r   [0:NCH-1];
  reg  [NCH-1:0] force_r;
  reg  [NCH-1:0] pend_r;
  reg  [NCH-1:0] pp_r;
  reg  [NCH-1:0] on_d_r;
  reg  [NCH-1:0] xcol_r;
  reg  [NCH-1:0] pcol_r;
  reg  [1:0]     st_r;
  reg  [2:0]     ch_r;

  reg  [15:0]    rd_val;
  reg  [NCH-1:0] on_vec;
  reg  [NCH-1:0] req_vec;
  reg            hit;
  reg            pp_nxt;
  integer        i;
  integer        j;

  wire [2:0]     a_ch   = paddr[`CH_FIELD_HI:`CH_FIELD_LO];
  wire [2:0]     a_reg  = paddr[`REG_FIELD_HI:`REG_FIELD_LO];
  wire           a_stat = paddr[`STAT_SEL_BIT];
  wire           a_top0 = (paddr[11:9] == 3'h0);
  wire           apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire [2:0]     gnt_idx;
  wire           gnt_any;

  wire [15:0]    cctl   = ctl_r[ch_r];
  wire [1:0]     cam    = cctl[`CTL_AM_HI:`CTL_AM_LO];
  wire           cdir   = cctl[`CTL_DIR];
  wire [15:0]    gctl   = ctl_r[gnt_idx];
  wire [1:0]     gam    = gctl[`CTL_AM_HI:`CTL_AM_LO];
  wire           xcol_hit = ram_we & cpu_ram_we & (cpu_ram_addr == ram_addr);
  wire           pcol_hit = per_we & cpu_per_we & (cpu_per_addr == per_addr);

  function [15:0] step_of;
    input byte_mode;
    begin
      step_of = byte_mode ? `STEP_BYTE : `STEP_WORD;  // [RL6]
    end
  endfunction

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  dma8_arbiter #(
    .NCH (NCH),
    .IW  (3)
  ) u_arb (
    .req     (req_vec),
    .gnt_idx (gnt_idx),
    .any     (gnt_any)
  );

  always @* begin
    pp_nxt = pp_r[ch_r] ^ cctl[`CTL_MODE_PP];
    for (j = 0; j < NCH; j = j + 1) begin
      on_vec[j]  = ctl_r[j][`CTL_ON];
      req_vec[j] = ctl_r[j][`CTL_ON] & (pend_r[j] | force_r[j]);  // [RL7] [RL8] [RL23]
    end
  end

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  always @* begin
    rd_val = `RESET_HW;
    hit    = 1'b0;
    if (a_top0 && a_stat) begin
      if (paddr[7:2] == {3'h0, `REG_CS0}) begin
        hit    = 1'b1;
        rd_val = {pcol_r, xcol_r};  // [RL17]
      end else if (paddr[7:2] == {3'h0, `REG_CS1}) begin
        hit    = 1'b1;
        rd_val = {pp_r, on_vec};  // [RL17]
      end
    end else if (a_top0) begin
      hit = 1'b1;
      case (a_reg)
        `REG_CTL: rd_val = ctl_r[a_ch];
        `REG_REQ: rd_val = {force_r[a_ch], 8'h00, sel_r[a_ch]};
        `REG_STA: rd_val = ptr_r[a_ch];  // [RL15]
        `REG_STB: rd_val = ptr_r[a_ch];  // [RL15]
        `REG_PAD: rd_val = pad_r[a_ch];
        `REG_CNT: rd_val = {6'h00, cnt_r[a_ch]};
        default: begin
          hit    = 1'b0;
          rd_val = `RESET_HW;
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers, requests and transfer engine
  // ****************************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < NCH; i = i + 1) begin
        ctl_r[i] <= `RESET_HW;
        sel_r[i] <= 7'h00;
        sta_r[i] <= `RESET_HW;
        stb_r[i] <= `RESET_HW;
        pad_r[i] <= `RESET_HW;
        cnt_r[i] <= 10'h000;
        ptr_r[i] <= `RESET_HW;
        idx_r[i] <= 10'h000;
      end
      force_r   <= {NCH{1'b0}};
      pend_r    <= {NCH{1'b0}};
      pp_r      <= {NCH{1'b0}};
      on_d_r    <= {NCH{1'b0}};
      xcol_r    <= {NCH{1'b0}};
      pcol_r    <= {NCH{1'b0}};
      st_r      <= S_IDLE;
      ch_r      <= 3'h0;
      prdata    <= 32'h00000000;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
      ram_addr  <= 16'h0000;
      ram_wdata <= 16'h0000;
      ram_re    <= 1'b0;
      ram_we    <= 1'b0;
      xfer_byte <= 1'b0;
      per_addr  <= 16'h0000;
      per_wdata <= 16'h0000;
      per_re    <= 1'b0;
      per_we    <= 1'b0;
      chan_irq  <= {NCH{1'b0}};
    end else if (ce) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      chan_irq <= {NCH{1'b0}};

      // Transfer engine on the dedicated bus, independent of the processor  [RL3]
      case (st_r)
        S_IDLE: begin
          if (gnt_any) begin
            ch_r           <= gnt_idx;
            pend_r[gnt_idx] <= 1'b0;
            xfer_byte      <= gctl[`CTL_SIZE];
            per_addr       <= pad_r[gnt_idx];
            // Modes 10 and 11 take the address from the peripheral  [RL4] [RL20]
            ram_addr       <= gam[1] ? periph_ind_addr : ptr_r[gnt_idx];
            ram_re         <= gctl[`CTL_DIR];  // [RL2] [RL22]
            per_re         <= ~gctl[`CTL_DIR];  // [RL22]
            st_r           <= S_RD;
          end
        end
        S_RD: begin
          ram_re <= 1'b0;
          per_re <= 1'b0;
          st_r   <= S_WAIT;
        end
        S_WAIT: begin
          if (cdir) begin
            per_we    <= 1'b1;  // [RL22]
            per_wdata <= ram_rdata;
          end else begin
            ram_we    <= 1'b1;  // [RL22]
            ram_wdata <= per_rdata;
            // Null write also pokes the peripheral with zero
            per_we    <= cctl[`CTL_NULL_WRITE_MODE];
            per_wdata <= 16'h0000;
          end
          st_r <= S_WR;
        end
        S_WR: begin
          ram_we         <= 1'b0;
          per_we         <= 1'b0;
          force_r[ch_r]  <= 1'b0;  // [RL21]
          st_r           <= S_IDLE;
          if (idx_r[ch_r] == cnt_r[ch_r]) begin  // [RL19]
            idx_r[ch_r] <= 10'h000;
            pp_r[ch_r]  <= pp_nxt;  // [RL10]
            ptr_r[ch_r] <= pp_nxt ? stb_r[ch_r] : sta_r[ch_r];  // [RL9] [RL10]
            if (!cctl[`CTL_HALF]) begin
              chan_irq[ch_r] <= 1'b1;  // [RL5] [RL18]
            end
            // One-shot ends after the block, or after the second buffer in ping-pong
            if (cctl[`CTL_MODE_ONE] && (!cctl[`CTL_MODE_PP] || pp_r[ch_r])) begin
              ctl_r[ch_r][`CTL_ON] <= 1'b0;  // [RL9]
            end
          end else begin
            idx_r[ch_r] <= idx_r[ch_r] + 10'h001;
            if (cam == `AM_POSTINC) begin
              ptr_r[ch_r] <= ptr_r[ch_r] + step_of(cctl[`CTL_SIZE]);  // [RL4] [RL6]
            end
            if (cctl[`CTL_HALF] && (idx_r[ch_r] == {1'b0, cnt_r[ch_r][9:1]})) begin
              chan_irq[ch_r] <= 1'b1;  // [RL5]
            end
          end
        end
        default: st_r <= S_IDLE;
      endcase

      // Per-channel enable edge and peripheral trigger  [RL1]
      for (i = 0; i < NCH; i = i + 1) begin
        on_d_r[i] <= ctl_r[i][`CTL_ON];
        if (ctl_r[i][`CTL_ON] && !on_d_r[i]) begin
          ptr_r[i] <= sta_r[i];
          idx_r[i] <= 10'h000;
          pp_r[i]  <= 1'b0;
        end
        // Source index is the seven-bit code, e.g. 0001011, 0000010, 0001101  [RL11] [RL12] [RL13] [RL14]
        if (ctl_r[i][`CTL_ON] && irq_src[sel_r[i]]) begin
          pend_r[i] <= 1'b1;  // [RL8]
        end
      end

      // APB slave: one-cycle access phase
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= ~hit;
        prdata  <= {16'h0000, rd_val};
      end
      // Writes while a channel runs are taken as is  [RL24]
      if (apb_wr && !a_stat) begin
        case (a_reg)
          `REG_CTL: ctl_r[a_ch] <= pwdata[15:0] & `CTL_MASK;  // [RL16]
          `REG_REQ: begin
            sel_r[a_ch] <= pwdata[6:0] & `SEL_MASK;  // [RL11]
            if (pwdata[`REQ_FORCE]) begin
              force_r[a_ch] <= 1'b1;  // [RL8] [RL21]
            end
          end
          `REG_STA: sta_r[a_ch] <= pwdata[15:0];  // [RL15]
          `REG_STB: stb_r[a_ch] <= pwdata[15:0];  // [RL15]
          `REG_PAD: pad_r[a_ch] <= pwdata[15:0];
          `REG_CNT: cnt_r[a_ch] <= pwdata[9:0] & `CNT_MASK;  // [RL16]
          default: ;
        endcase
      end
      // Writing one clears a collision flag; a new collision wins
      if (apb_wr && a_stat && (paddr[7:2] == {3'h0, `REG_CS0})) begin
        xcol_r <= xcol_r & ~pwdata[7:0];
        pcol_r <= pcol_r & ~pwdata[15:8];
      end
      if (xcol_hit) begin
        xcol_r[ch_r] <= 1'b1;  // [RL17]
      end
      if (pcol_hit) begin
        pcol_r[ch_r] <= 1'b1;  // [RL17]
      end
    end
  end

endmodule

// File: dma8_consts.vh
// Purpose: Shared constants of the eight-channel transfer controller
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are byte addresses on the register bus
`ifndef DMA8_CONSTS_VH
`define DMA8_CONSTS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define CH_FIELD_HI      7
`define CH_FIELD_LO      5
`define REG_FIELD_HI     4
`define REG_FIELD_LO     2
`define STAT_SEL_BIT     8
`define REG_CTL          3'h0
`define REG_REQ          3'h1
`define REG_STA          3'h2
`define REG_STB          3'h3
`define REG_PAD          3'h4
`define REG_CNT          3'h5
`define REG_CS0          3'h0
`define REG_CS1          3'h1

// ****************************************************************
// Field positions and masks
// ****************************************************************
`define CTL_ON           15
`define CTL_SIZE         14
`define CTL_DIR          13
`define CTL_HALF         12
`define CTL_NULL_WRITE_MODE        11
`define CTL_AM_HI        5
`define CTL_AM_LO        4
`define CTL_MODE_PP      1
`define CTL_MODE_ONE     0
`define CTL_MASK         16'hF833
`define REQ_FORCE        15
`define SEL_MASK         7'h7F
`define CNT_MASK         10'h3FF
`define RESET_HW         16'h0000

// ****************************************************************
// Addressing modes and steps
// ****************************************************************
`define AM_POSTINC       2'h0
`define AM_NOINC         2'h1
`define AM_PERIPH        2'h2
`define STEP_BYTE        16'h0001
`define STEP_WORD        16'h0002

// ****************************************************************
// Source codes and peripheral addresses of common sources
// ****************************************************************
`define SRC_SERIAL1_RX   7'h0B
`define ADR_SERIAL1_RX   16'h0226
`define SRC_COMPARE1     7'h02
`define ADR_COMPARE1_P   16'h0182
`define ADR_COMPARE1_S   16'h0180
`define SRC_CONV1_DONE   7'h0D
`define ADR_CONV1_RES    16'h0300

`endif

// File: dma8_arbiter.v
// Purpose: Fixed-priority pick of one requesting channel
// Assumes: Combinational; caller registers the result
// Notes:   Channel 0 has highest priority
`timescale 1ns/1ps

module dma8_arbiter #(
  parameter NCH = 8,
  parameter IW  = 3
) (
  input  wire [NCH-1:0] req,
  output reg  [IW-1:0]  gnt_idx,
  output wire           any
);

  integer i;

  assign any = |req;

  // ****************************************************************
  // Lowest index wins
  // ****************************************************************
  always @* begin
    gnt_idx = {IW{1'b0}};
    for (i = NCH - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        gnt_idx = i[IW-1:0];
      end
    end
  end

endmodule

// File: dma8_ctl_chk.sv
// Purpose: Port assertions for the transfer controller
// Assumes: Bound to dma8_controller; one clock domain
// Notes:   Watches design-driven outputs plus the psel and penable inputs
`timescale 1ns/1ps
module dma8_ctl_chk #(
  parameter NCH = 8
) (
  input wire           pclk,
  input wire           presetn,
  input wire           psel,
  input wire           penable,
  input wire           pready,
  input wire           pslverr,
  input wire           ram_re,
  input wire           ram_we,
  input wire           per_re,
  input wire           per_we,
  input wire [15:0]    ram_addr,
  input wire [NCH-1:0] chan_irq
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  ram_to_per_a: assert property (ram_re |-> ##2 (per_we && !ram_we))
    else $error("ram read not followed by periph write");
  per_to_ram_a: assert property (per_re |-> ##2 ram_we)
    else $error("periph read not followed by ram write");
  xfer_spacing_a: assert property ((ram_re || per_re) |=> !(ram_re || per_re) [*3])
    else $error("transfers too close");
  addr_hold_a: assert property (ram_re |=> $stable(ram_addr) [*2])
    else $error("ram address moved mid transfer");
  irq_cause_a: assert property ((|chan_irq) |-> $past(ram_we || per_we))
    else $error("irq without a write before it");
  irq_single_a: assert property ($onehot0(chan_irq))
    else $error("two channel irqs at once");
  one_source_a: assert property (!(ram_re && per_re))
    else $error("both buses read at once");
endmodule
bind dma8_controller dma8_ctl_chk #(.NCH(NCH)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .ram_re(ram_re), .ram_we(ram_we), .per_re(per_re), .per_we(per_we),
  .ram_addr(ram_addr), .chan_irq(chan_irq));

// File: dma8_xfer_partner.sv
// Purpose: RAM and peripheral read side of the transaction bus
// Assumes: Data is due the cycle after the read strobe
// Notes:   Outside that cycle the data lines toggle
`timescale 1ns/1ps
module dma8_xfer_partner (
  input  wire        pclk,
  input  wire [15:0] ram_addr,
  input  wire        ram_re,
  output logic [15:0] ram_rdata,
  input  wire [15:0] per_addr,
  input  wire        per_re,
  output logic [15:0] per_rdata
);
  initial ram_rdata = 16'h0000;
  initial per_rdata = 16'h0000;
  // ****************************************
  // Read answers, one cycle after strobe
  // ****************************************
  always @(posedge pclk) begin
    ram_rdata <= ram_re ? (ram_addr ^ 16'hA5C3) : ~ram_rdata;
    per_rdata <= per_re ? (per_addr + 16'h1111) : ~per_rdata;
  end
endmodule

// File: eight_channel_dma_controller_bench.sv
// Purpose: Self-checking bench of the transfer controller
// Assumes: APB master changes signals after rising edges
// Notes:   Xorshift stimulus from a fixed seed
`timescale 1ns/1ps
`include "dma8_consts.vh"
`define EXPECT(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module eight_channel_dma_controller_bench;
  logic         pclk = 0;
  logic         presetn = 0;
  logic         psel = 0;
  logic         penable = 0;
  logic         pwrite = 0;
  logic [11:0]  paddr = 0;
  logic [31:0]  pwdata = 0;
  logic [127:0] irq_src = 0;
  logic [15:0]  ind_addr = 0;
  wire  [31:0]  prdata;
  wire          pready, pslverr, ram_re, ram_we, xfer_byte, per_re, per_we;
  wire  [15:0]  ram_addr, ram_wdata, ram_rdata, per_addr, per_wdata, per_rdata;
  wire  [7:0]   chan_irq;
  int           err_count = 0;
  int           n_checks = 0;
  logic [31:0]  seed = 32'h851EC8EE;
  logic [31:0]  rd, v;
  logic         er;
  logic [15:0]  ad, dt, s, s2, pv;
  logic         cpu_we = 0;
  logic [15:0]  cpu_radr = 0;
  logic [15:0]  cpu_padr = 0;
  logic [7:0]   iq;
  always #10 pclk = ~pclk;
  dma8_controller DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq_src(irq_src), .periph_ind_addr(ind_addr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_re(ram_re), .ram_we(ram_we),
    .xfer_byte(xfer_byte), .per_addr(per_addr), .per_wdata(per_wdata), .per_rdata(per_rdata),
    .per_re(per_re), .per_we(per_we), .cpu_ram_we(cpu_we), .cpu_ram_addr(cpu_radr),
    .cpu_per_we(cpu_we), .cpu_per_addr(cpu_padr), .chan_irq(chan_irq));
  dma8_xfer_partner u_mem (.pclk(pclk), .ram_addr(ram_addr), .ram_re(ram_re), .ram_rdata(ram_rdata),
    .per_addr(per_addr), .per_re(per_re), .per_rdata(per_rdata));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [15:0] ram_pat(input logic [15:0] a);
    return a ^ 16'hA5C3;
  endfunction
  function automatic logic [15:0] per_pat(input logic [15:0] a);
    return a + 16'h1111;
  endfunction
  function automatic logic [11:0] ra(input logic [2:0] c, input logic [2:0] r);
    return {4'h0, c, r, 2'b00};
  endfunction
  task report_and_stop();
    $display("Counts: errors %0d checks %0d", err_count, n_checks);
    if (err_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task fail_wait();
    err_count++;
    $display("[FAIL] %0t wait bound used up", $time);
    report_and_stop();
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) fail_wait();
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic xw();
    int k;
    for (k = 0; k < 30; k++) begin
      @(posedge pclk);
      #1;
      if ((per_we | ram_we) === 1'b1) break;
    end
    if (k == 30) fail_wait();
    ad = per_we ? per_addr : ram_addr;
    dt = per_we ? per_wdata : ram_wdata;
    @(posedge pclk);
    #1;
    iq = chan_irq;
  endtask
  task automatic pulse(input logic [6:0] code);
    @(posedge pclk);
    irq_src <= 128'h1 << code;
    @(posedge pclk);
    irq_src <= '0;
  endtask
  task automatic setup(input logic [2:0] c, input logic [15:0] st, input logic [15:0] pa,
                       input logic [6:0] code, input logic [15:0] ctl, input logic [31:0] n);
    apb(1'b1, ra(c, `REG_STA), {16'h0, st});
    apb(1'b1, ra(c, `REG_PAD), {16'h0, pa});
    apb(1'b1, ra(c, `REG_CNT), n);
    apb(1'b1, ra(c, `REG_REQ), {25'h0, code});
    apb(1'b1, ra(c, `REG_CTL), {16'h0, ctl});
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      v = rnd();
      apb(1'b0, ra(3'(c), `REG_CTL), 0);
      `EXPECT(rd, 32'h0);
      apb(1'b1, ra(3'(c), `REG_PAD), v);
      apb(1'b0, ra(3'(c), `REG_PAD), 0);
      `EXPECT(rd, {16'h0, v[15:0]});
      apb(1'b1, ra(3'(c), `REG_CNT), v);
      apb(1'b0, ra(3'(c), `REG_CNT), 0);
      `EXPECT(rd, {22'h0, v[9:0]});
      apb(1'b1, ra(3'(c), `REG_CTL), v & 32'h7FFF);
      apb(1'b0, ra(3'(c), `REG_CTL), 0);
      `EXPECT(rd, {16'h0, v[15:0] & `CTL_MASK & 16'h7FFF});
      apb(1'b1, ra(3'(c), `REG_REQ), v & 32'h7F);
      apb(1'b0, ra(3'(c), `REG_REQ), 0);
      `EXPECT(rd, {25'h0, v[6:0]});
    end
    apb(1'b0, 12'h018, 0);
    `EXPECT({er, rd}, 33'h100000000);
    s = rnd() & 32'hFFFE;
    setup(3'd0, s, `ADR_COMPARE1_P, `SRC_COMPARE1, 16'hA001, 32'h3);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ra(3'd0, `REG_REQ), 32'h8000 | `SRC_COMPARE1);
      xw();
      `EXPECT(ad, `ADR_COMPARE1_P);
      `EXPECT(dt, ram_pat(s + 16'(2 * i)));
      `EXPECT(iq, (i == 3) ? 8'h01 : 8'h00);
      if (i == 0) begin
        apb(1'b0, ra(3'd0, `REG_STA), 0);
        `EXPECT(rd, {16'h0, s + 16'h2});
        apb(1'b0, ra(3'd0, `REG_REQ), 0);
        `EXPECT(rd, {25'h0, `SRC_COMPARE1});
      end
    end
    s = rnd() & 32'hFFFE;
    s2 = rnd() & 32'hFFFE;
    apb(1'b1, ra(3'd1, `REG_STB), {16'h0, s2});
    setup(3'd1, s, `ADR_COMPARE1_S, `SRC_COMPARE1, 16'hB002, 32'h1);
    cpu_padr <= `ADR_COMPARE1_S;
    cpu_we <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, ra(3'd1, `REG_REQ), 32'h8000 | `SRC_COMPARE1);
      xw();
      `EXPECT(ad, `ADR_COMPARE1_S);
      `EXPECT(dt, ram_pat((i == 2) ? s2 : s + 16'(2 * i)));
      `EXPECT(iq, (i == 1) ? 8'h00 : 8'h02);
    end
    s = rnd() & 32'hFFFE;
    pv = per_pat(`ADR_SERIAL1_RX);
    setup(3'd2, s, `ADR_SERIAL1_RX, `SRC_SERIAL1_RX, 16'hC010, 32'h1);
    cpu_radr <= s;
    for (int i = 0; i < 3; i++) begin
      pulse(`SRC_SERIAL1_RX);
      xw();
      `EXPECT(ad, s);
      `EXPECT({xfer_byte, dt[7:0]}, {1'b1, pv[7:0]});
      `EXPECT(per_addr, `ADR_SERIAL1_RX);
      `EXPECT(iq, (i == 1) ? 8'h04 : 8'h00);
    end
    @(posedge pclk);
    cpu_we <= 1'b0;
    s = rnd() & 32'hFFFE;
    ind_addr <= rnd() & 32'hFFFE;
    setup(3'd3, s, `ADR_CONV1_RES, `SRC_CONV1_DONE, 16'h8000, 32'h3);
    setup(3'd5, s, `ADR_CONV1_RES, `SRC_CONV1_DONE, 16'h8030, 32'h3);
    pulse(`SRC_CONV1_DONE);
    xw();
    `EXPECT(ad, s);
    `EXPECT(dt, per_pat(`ADR_CONV1_RES));
    xw();
    `EXPECT(ad, ind_addr);
    apb(1'b0, 12'h100, 0);
    `EXPECT(rd, 32'h00000204);
    apb(1'b1, 12'h100, 32'h00000200);
    apb(1'b0, 12'h100, 0);
    `EXPECT(rd, 32'h00000004);
    apb(1'b0, 12'h104, 0);
    `EXPECT(rd, 32'h0000022E);
    report_and_stop();
  end
endmodule
